// ---- rtl/pfbms_pkg.sv ----
// Constants shared by the pad function mux and the board mux controller.
// Assumes both ends run on one 100 MHz clock with a synchronous active-low reset.
package pfbms_pkg;
  // ----------------------------------------
  // Pad numbering
  // ----------------------------------------
  localparam int NPAD = 39;
  localparam int PAD_MEM = 0;
  localparam int NMEM = 10;
  localparam int PAD_CTL = 10;
  localparam int NCTL = 5;
  localparam int PAD_DAT = 15;
  localparam int NDAT = 24;
  localparam int SEL_W = 3;

  // ----------------------------------------
  // Function numbers and reset selection
  // ----------------------------------------
  localparam logic [2:0] FN_1 = 3'h1;
  localparam logic [2:0] FN_2 = 3'h2;
  localparam logic [2:0] FN_4 = 3'h4;
  localparam logic [2:0] FN_5 = 3'h5;
  localparam logic [2:0] FN_6 = 3'h6;
  localparam logic [2:0] SEL_RST = FN_1;

  // ----------------------------------------
  // Positions inside pad groups
  // ----------------------------------------
  localparam int EMMC_HI_LAST = 3;
  localparam int EMMC_CLK_PAD = 4;
  localparam int EMMC_CMD_PAD = 9;
  localparam int CTL_CLK = 0;
  localparam int CTL_DE = 1;
  localparam int CTL_FLD = 2;
  localparam int TRACE_CTL_BASE = 5;
  localparam int TRACE_DAT_BASE = 10;
  localparam int TRACE_DAT_LAST = 9;
  localparam int VOUT_DAT_TOP = 23;
  localparam int MDIO_CLK_DAT = 10;
  localparam int MDIO_D_DAT = 11;
  localparam int TXC_DAT = 12;
  localparam int TXCTL_DAT = 13;
  localparam int TXD_LAST = 17;
  localparam int RXC_DAT = 18;
  localparam int RXCTL_DAT = 19;
  localparam int RXD_LAST = 23;

  // ----------------------------------------
  // Pad select register space on the link
  // ----------------------------------------
  localparam int CFG_AW = 6;
  localparam logic [5:0] CFG_NPAD = 6'h27;
  localparam logic [5:0] CFG_STATUS = 6'h30;

  // ----------------------------------------
  // Controller register port
  // ----------------------------------------
  localparam int AW = 9;
  localparam int DW = 32;
  localparam logic [8:0] REG_EXP2 = 9'h000;
  localparam logic [8:0] REG_EXP3 = 9'h004;
  localparam logic [8:0] REG_CTRL = 9'h008;
  localparam logic [8:0] REG_STAT = 9'h00c;
  localparam int PAD_WIN_BIT = 8;

  // ----------------------------------------
  // Expander images and board mux fields
  // ----------------------------------------
  localparam int EXP_W = 18;
  localparam logic [17:0] EXP2_RST = 18'h00000;
  localparam logic [17:0] EXP3_RST = 18'h00000;
  localparam int EXP3_MUXC_HI = 15;
  localparam int EXP3_MUXC_LO = 14;
  localparam int EXP3_MUXD_HI = 6;
  localparam int EXP3_MUXD_LO = 2;
  localparam int EXP2_MUXE_HI = 17;
  localparam int EXP2_MUXE_LO = 14;
  localparam int EXP3_MUXF_HI = 12;
  localparam int EXP3_MUXF_LO = 11;
  localparam int EXP2_MUXJ = 4;
  localparam logic [1:0] MUXC_EMMC = 2'h1;
  localparam logic [1:0] MUXC_NOR = 2'h2;
  localparam logic [1:0] MUXD_ONBOARD = 2'h0;
  localparam logic [1:0] MUXE_TRACE = 2'h0;
  localparam logic [1:0] MUXF_GIG = 2'h0;
  localparam logic MUXJ_GIG = 1'b0;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage

// ---- rtl/pfbms_if.sv ----
// Link between the board mux controller and the pad function mux.
// Assumes both ends share i_clk_sys; no signal here needs a synchroniser.
`timescale 1ns/10ps
interface pfbms_if;
  logic [5:0] cfg_addr;
  logic [2:0] cfg_wdata;
  logic cfg_wr;
  logic [2:0] cfg_rdata;
  logic first_port_sel;

  modport dev (
    input cfg_addr,
    input cfg_wdata,
    input cfg_wr,
    input first_port_sel,
    output cfg_rdata
  );
  modport ctl (
    output cfg_addr,
    output cfg_wdata,
    output cfg_wr,
    output first_port_sel,
    input cfg_rdata
  );
endinterface

// ---- rtl/pfbms_pad_mux.sv ----
// Pad function mux: per-pad function select for the memory/eMMC pads and the
// video-input-A control and data pads.
// Assumes pad inputs are asynchronous and the controller end writes the selects.
// What this block and the board mux controller do
// RQ1: Memory pads carry memory bus or eMMC port
// RQ2: eMMC pins map to fixed address pads
// RQ3: Expander three P15/P14 set board mux C
// RQ4: eMMC boot lets DIP position three choose
// RQ5: Video pads offer input, output, trace functions
// RQ6: Function four gives port B enable, syncs
// RQ7: Mux D via P6/P2, onboard by default
// RQ8: Mux E via P17/P14, trace by default
// RQ9: Data pads 10-23 give MDIO/RGMII or output
// RQ10: Mux F via P12/P11, Ethernet by default
// RQ11: MDIO on pads only without first port
// RQ12: Mux J via P4, gigabit by default
// RQ13: Only selected function drives or hears pad
`timescale 1ns/10ps
module pfbms_pad_mux (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  pfbms_if.dev bus,
  input wire logic [38:0] i_pad_in,
  output logic [38:0] o_pad_out,
  output logic [38:0] o_pad_oe,
  input wire logic [9:0] i_mem_out,
  input wire logic [9:0] i_mem_oe,
  output logic [9:0] o_mem_in,
  input wire logic i_emmc_clk,
  input wire logic i_emmc_cmd_out,
  input wire logic i_emmc_cmd_oe,
  output logic o_emmc_cmd_in,
  input wire logic [7:0] i_emmc_dat_out,
  input wire logic [7:0] i_emmc_dat_oe,
  output logic [7:0] o_emmc_dat_in,
  output logic [4:0] o_vin_a_ctl,
  output logic [23:0] o_vin_a_d,
  output logic [2:0] o_vin_b_ctl,
  input wire logic [4:0] i_vout_ctl,
  input wire logic [23:0] i_vout_d,
  input wire logic [19:5] i_trace_out,
  input wire logic [19:5] i_trace_oe,
  output logic [19:5] o_trace_in,
  input wire logic i_mdio_clk,
  input wire logic i_mdio_d_out,
  input wire logic i_mdio_d_oe,
  output logic o_mdio_d_in,
  input wire logic i_rgmii_txc,
  input wire logic i_rgmii_txctl,
  input wire logic [3:0] i_rgmii_txd,
  output logic o_rgmii_rxc,
  output logic o_rgmii_rxctl,
  output logic [3:0] o_rgmii_rxd
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [38:0][2:0] sel;
    logic [38:0] s1;
    logic [38:0] s2;
    logic [38:0] s3;
    logic [38:0] filt;
    logic [38:0] pad_out;
    logic [38:0] pad_oe;
    logic [9:0] mem_in;
    logic emmc_cmd_in;
    logic [7:0] emmc_dat_in;
    logic [4:0] vin_a_ctl;
    logic [23:0] vin_a_d;
    logic [2:0] vin_b_ctl;
    logic [19:5] trace_in;
    logic mdio_d_in;
    logic rxc;
    logic rxctl;
    logic [3:0] rxd;
  } pfbms_pad_st_t;

  localparam pfbms_pad_st_t ST_RST = '{sel: {39{pfbms_pkg::SEL_RST}}, default: '0};

  pfbms_pad_st_t st;
  pfbms_pad_st_t next_st;
  logic mdio_pads_ok;
  int p;
  int k;

  // MDIO may come from the video pads only while the first port is off
  assign mdio_pads_ok = !bus.first_port_sel;  // [RQ11]

  // ----------------------------------------
  // Select readback on the link
  // ----------------------------------------
  always_comb begin
    if (bus.cfg_addr < pfbms_pkg::CFG_NPAD) begin
      bus.cfg_rdata = st.sel[bus.cfg_addr];
    end else if (bus.cfg_addr == pfbms_pkg::CFG_STATUS) begin
      bus.cfg_rdata = {2'h0, mdio_pads_ok};
    end else begin
      bus.cfg_rdata = 3'h0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    // Unselected functions see zero and leave the pad undriven
    next_st = '{sel: st.sel, s1: i_pad_in, s2: st.s1, s3: st.s2, filt: st.filt, default: '0};  // [RQ13]
    for (p = 0; p < pfbms_pkg::NPAD; p++) begin
      if (st.s2[p] == st.s3[p]) begin
        next_st.filt[p] = st.s3[p];
      end
    end
    if (bus.cfg_wr && (bus.cfg_addr < pfbms_pkg::CFG_NPAD)) begin
      next_st.sel[bus.cfg_addr] = bus.cfg_wdata;  // [RQ13]
    end
    // Memory bus upper address and chip select pads
    for (k = 0; k < pfbms_pkg::NMEM; k++) begin
      p = pfbms_pkg::PAD_MEM + k;
      case (st.sel[p])
        pfbms_pkg::FN_1: begin
          next_st.pad_out[p] = i_mem_out[k];  // [RQ1]
          next_st.pad_oe[p] = i_mem_oe[k];
          next_st.mem_in[k] = st.filt[p];
        end
        pfbms_pkg::FN_2: begin
          if (k <= pfbms_pkg::EMMC_HI_LAST) begin
            next_st.pad_out[p] = i_emmc_dat_out[k + 4];  // [RQ2]
            next_st.pad_oe[p] = i_emmc_dat_oe[k + 4];
            next_st.emmc_dat_in[k + 4] = st.filt[p];
          end else if (k == pfbms_pkg::EMMC_CLK_PAD) begin
            next_st.pad_out[p] = i_emmc_clk;  // [RQ2]
            next_st.pad_oe[p] = 1'b1;
          end else if (k == pfbms_pkg::EMMC_CMD_PAD) begin
            next_st.pad_out[p] = i_emmc_cmd_out;  // [RQ2]
            next_st.pad_oe[p] = i_emmc_cmd_oe;
            next_st.emmc_cmd_in = st.filt[p];
          end else begin
            next_st.pad_out[p] = i_emmc_dat_out[k - 5];  // [RQ1]
            next_st.pad_oe[p] = i_emmc_dat_oe[k - 5];
            next_st.emmc_dat_in[k - 5] = st.filt[p];
          end
        end
        default: begin
        end
      endcase
    end

    // Video-input-A clock, enable, field and sync pads
    for (k = 0; k < pfbms_pkg::NCTL; k++) begin
      p = pfbms_pkg::PAD_CTL + k;
      case (st.sel[p])
        pfbms_pkg::FN_1: begin
          next_st.vin_a_ctl[k] = st.filt[p];  // [RQ5]
        end
        pfbms_pkg::FN_4: begin
          // Clock and field pads have no function 4
          if (k == pfbms_pkg::CTL_DE) begin
            next_st.vin_b_ctl[0] = st.filt[p];  // [RQ6]
          end else if (k > pfbms_pkg::CTL_FLD) begin
            next_st.vin_b_ctl[k - 2] = st.filt[p];  // [RQ6]
          end
        end
        pfbms_pkg::FN_5: begin
          // Clock pad carries output field, field pad carries output clock
          if (k == pfbms_pkg::CTL_CLK) begin
            next_st.pad_out[p] = i_vout_ctl[pfbms_pkg::CTL_FLD];  // [RQ5]
          end else if (k == pfbms_pkg::CTL_FLD) begin
            next_st.pad_out[p] = i_vout_ctl[pfbms_pkg::CTL_CLK];  // [RQ5]
          end else begin
            next_st.pad_out[p] = i_vout_ctl[k];
          end
          next_st.pad_oe[p] = 1'b1;
        end
        pfbms_pkg::FN_6: begin
          next_st.pad_out[p] = i_trace_out[pfbms_pkg::TRACE_CTL_BASE + k];  // [RQ5]
          next_st.pad_oe[p] = i_trace_oe[pfbms_pkg::TRACE_CTL_BASE + k];
          next_st.trace_in[pfbms_pkg::TRACE_CTL_BASE + k] = st.filt[p];
        end
        default: begin
        end
      endcase
    end

    // Video-input-A data pads 0..23
    for (k = 0; k < pfbms_pkg::NDAT; k++) begin
      p = pfbms_pkg::PAD_DAT + k;
      case (st.sel[p])
        pfbms_pkg::FN_1: begin
          next_st.vin_a_d[k] = st.filt[p];  // [RQ5]
        end
        pfbms_pkg::FN_4: begin
          if ((k == pfbms_pkg::MDIO_CLK_DAT) && mdio_pads_ok) begin
            next_st.pad_out[p] = i_mdio_clk;  // [RQ9] [RQ11]
            next_st.pad_oe[p] = 1'b1;
          end else if ((k == pfbms_pkg::MDIO_D_DAT) && mdio_pads_ok) begin
            next_st.pad_out[p] = i_mdio_d_out;  // [RQ9] [RQ11]
            next_st.pad_oe[p] = i_mdio_d_oe;
            next_st.mdio_d_in = st.filt[p];
          end else if (k == pfbms_pkg::TXC_DAT) begin
            next_st.pad_out[p] = i_rgmii_txc;  // [RQ9]
            next_st.pad_oe[p] = 1'b1;
          end else if (k == pfbms_pkg::TXCTL_DAT) begin
            next_st.pad_out[p] = i_rgmii_txctl;  // [RQ9]
            next_st.pad_oe[p] = 1'b1;
          end else if ((k > pfbms_pkg::TXCTL_DAT) && (k <= pfbms_pkg::TXD_LAST)) begin
            next_st.pad_out[p] = i_rgmii_txd[pfbms_pkg::TXD_LAST - k];  // [RQ9]
            next_st.pad_oe[p] = 1'b1;
          end else if (k == pfbms_pkg::RXC_DAT) begin
            next_st.rxc = st.filt[p];  // [RQ9]
          end else if (k == pfbms_pkg::RXCTL_DAT) begin
            next_st.rxctl = st.filt[p];  // [RQ9]
          end else if ((k > pfbms_pkg::RXCTL_DAT) && (k <= pfbms_pkg::RXD_LAST)) begin
            next_st.rxd[pfbms_pkg::RXD_LAST - k] = st.filt[p];  // [RQ9]
          end
        end
        pfbms_pkg::FN_5: begin
          next_st.pad_out[p] = i_vout_d[pfbms_pkg::VOUT_DAT_TOP - k];  // [RQ5] [RQ9]
          next_st.pad_oe[p] = 1'b1;
        end
        pfbms_pkg::FN_6: begin
          if (k <= pfbms_pkg::TRACE_DAT_LAST) begin
            next_st.pad_out[p] = i_trace_out[pfbms_pkg::TRACE_DAT_BASE + k];  // [RQ5]
            next_st.pad_oe[p] = i_trace_oe[pfbms_pkg::TRACE_DAT_BASE + k];
            next_st.trace_in[pfbms_pkg::TRACE_DAT_BASE + k] = st.filt[p];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_pad_out = st.pad_out;
  assign o_pad_oe = st.pad_oe;
  assign o_mem_in = st.mem_in;
  assign o_emmc_cmd_in = st.emmc_cmd_in;
  assign o_emmc_dat_in = st.emmc_dat_in;
  assign o_vin_a_ctl = st.vin_a_ctl;
  assign o_vin_a_d = st.vin_a_d;
  assign o_vin_b_ctl = st.vin_b_ctl;
  assign o_trace_in = st.trace_in;
  assign o_mdio_d_in = st.mdio_d_in;
  assign o_rgmii_rxc = st.rxc;
  assign o_rgmii_rxctl = st.rxctl;
  assign o_rgmii_rxd = st.rxd;
endmodule

// ---- rtl/pfbms_board_ctl.sv ----
// Board mux controller: expander images for muxes C, D, E, F and J, the eMMC
// boot override of mux C, and the register port that also reaches pad selects.
// Assumes the DIP and boot strap pins are asynchronous to i_clk_sys.
`timescale 1ns/10ps
module pfbms_board_ctl (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  pfbms_if.ctl bus,
  input wire logic [8:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_dip_pos3,
  input wire logic i_boot_emmc,
  output logic [17:0] o_exp2,
  output logic [17:0] o_exp3
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic dip3;
    logic [1:0] strap_cnt;
    logic boot_emmc;
    logic exp_owns_c;
    logic [17:0] exp2;
    logic [17:0] exp3;
    logic [17:0] exp3_out;
    logic first_port;
    logic [31:0] rdata;
  } pfbms_ctl_st_t;

  localparam pfbms_ctl_st_t ST_RST = '{exp2: pfbms_pkg::EXP2_RST, exp3: pfbms_pkg::EXP3_RST,
    exp3_out: pfbms_pkg::EXP3_RST, first_port: 1'b1, default: '0};

  pfbms_ctl_st_t st;
  pfbms_ctl_st_t next_st;
  logic pad_win;
  logic dip_owns_c;
  logic [6:0] stat;

  assign pad_win = i_addr[pfbms_pkg::PAD_WIN_BIT];
  assign bus.cfg_addr = i_addr[7:2];
  assign bus.cfg_wdata = i_wdata[2:0];
  assign bus.cfg_wr = i_wr && pad_win;
  assign bus.first_port_sel = st.first_port;
  assign dip_owns_c = st.boot_emmc && !st.exp_owns_c;  // [RQ4]
  assign stat = {
    st.exp3[pfbms_pkg::EXP3_MUXF_HI:pfbms_pkg::EXP3_MUXF_LO] == pfbms_pkg::MUXF_GIG,
    {st.exp2[pfbms_pkg::EXP2_MUXE_HI], st.exp2[pfbms_pkg::EXP2_MUXE_LO]} == pfbms_pkg::MUXE_TRACE,
    {st.exp3[pfbms_pkg::EXP3_MUXD_HI], st.exp3[pfbms_pkg::EXP3_MUXD_LO]} == pfbms_pkg::MUXD_ONBOARD,
    dip_owns_c, st.first_port, st.dip3, st.boot_emmc};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = {i_boot_emmc, i_dip_pos3};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2[0] == st.s3[0]) begin
      next_st.dip3 = st.s3[0];
    end
    // Boot strap follows the filtered pin every cycle once the synchroniser has filled after reset
    if (st.strap_cnt != pfbms_pkg::STRAP_WAIT) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end else if (st.s2[1] == st.s3[1]) begin
      next_st.boot_emmc = st.s3[1];
    end
    if (i_wr && !pad_win) begin
      case (i_addr)
        pfbms_pkg::REG_EXP2: next_st.exp2 = i_wdata[17:0];  // [RQ8] [RQ12]
        pfbms_pkg::REG_EXP3: next_st.exp3 = i_wdata[17:0];  // [RQ3] [RQ7] [RQ10]
        pfbms_pkg::REG_CTRL: next_st.exp_owns_c = i_wdata[0];
        default: begin
        end
      endcase
    end
    next_st.exp3_out = st.exp3;
    if (dip_owns_c) begin
      next_st.exp3_out[pfbms_pkg::EXP3_MUXC_HI:pfbms_pkg::EXP3_MUXC_LO] =
        st.dip3 ? pfbms_pkg::MUXC_EMMC : pfbms_pkg::MUXC_NOR;  // [RQ4] [RQ3]
    end
    // Pad MDIO source follows the first-port mux automatically
    next_st.first_port = (st.exp2[pfbms_pkg::EXP2_MUXJ] == pfbms_pkg::MUXJ_GIG);  // [RQ11] [RQ12]
    next_st.rdata = '0;
    if (i_rd) begin
      if (pad_win) begin
        next_st.rdata = {29'h0, bus.cfg_rdata};
      end else begin
        case (i_addr)
          pfbms_pkg::REG_EXP2: next_st.rdata = {14'h0, st.exp2};
          pfbms_pkg::REG_EXP3: next_st.rdata = {14'h0, st.exp3};
          pfbms_pkg::REG_CTRL: next_st.rdata = {31'h0, st.exp_owns_c};
          pfbms_pkg::REG_STAT: next_st.rdata = {25'h0, stat};
          default: next_st.rdata = '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_exp2 = st.exp2;
  assign o_exp3 = st.exp3_out;
endmodule

// ---- testbench/pfbms_chk.sv ----
// Checker for the link between the two ends.
// Assumes it shares i_clk_sys and i_nrst with both ends.
`timescale 1ns/10ps
module pfbms_chk (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [5:0] cfg_addr,
  input wire logic [2:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_rdata,
  input wire logic first_port_sel
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------
  // Shadow of the pad selects
  // ----------------------------------------
  logic [2:0] shadow [0:pfbms_pkg::NPAD-1];
  logic touched;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      touched <= 1'b0;
      for (int n = 0; n < pfbms_pkg::NPAD; n++) begin
        shadow[n] <= pfbms_pkg::SEL_RST;
      end
    end else if (cfg_wr && cfg_addr < pfbms_pkg::CFG_NPAD) begin
      touched <= 1'b1;
      shadow[cfg_addr] <= cfg_wdata;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_sel_write;
    cfg_wr && cfg_addr < pfbms_pkg::CFG_NPAD;
  endsequence
  sequence s_same_addr;
    cfg_addr == $past(cfg_addr);
  endsequence
  property p_write_then_read;
    s_sel_write ##1 s_same_addr |-> cfg_rdata == $past(cfg_wdata);
  endproperty

  chk_sel_shadow: assert property (cfg_addr < pfbms_pkg::CFG_NPAD |-> cfg_rdata == shadow[cfg_addr])
    else $error("pad select readback differs from last write");
  chk_sel_untouched: assert property (!touched && cfg_addr < pfbms_pkg::CFG_NPAD |-> cfg_rdata == pfbms_pkg::SEL_RST)
    else $error("pad select not at reset function");
  chk_sel_after_reset: assert property ($rose(i_nrst) && cfg_addr < pfbms_pkg::CFG_NPAD |-> cfg_rdata == 3'h1)
    else $error("pad select wrong right after reset");
  chk_write_read: assert property (p_write_then_read)
    else $error("written pad select not visible next cycle");
  chk_status_mdio: assert property (cfg_addr == pfbms_pkg::CFG_STATUS |-> cfg_rdata[0] == !first_port_sel)
    else $error("mdio pad status does not follow first port select");
  chk_status_upper: assert property (cfg_addr == pfbms_pkg::CFG_STATUS |-> cfg_rdata[2:1] == 2'h0)
    else $error("status upper bits not zero");
  chk_index_range: assert property (cfg_addr >= pfbms_pkg::CFG_NPAD && cfg_addr != pfbms_pkg::CFG_STATUS
    |-> cfg_rdata == 3'h0)
    else $error("out of range pad index reads nonzero");
  chk_first_port_rst: assert property ($rose(i_nrst) |-> first_port_sel [*2])
    else $error("first port not selected after reset");
endmodule

// ---- testbench/tb_pad_function_and_board_mux_select.sv ----
// Bench for both ends joined by their link.
// Assumes the package, interface, both ends and checker compile first.
`timescale 1ns/10ps
module tb_pad_function_and_board_mux_select;
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_dip_pos3 = 1'b0, i_boot_emmc = 1'b0;
  logic [8:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [38:0] i_pad_in = '0, o_pad_out, o_pad_oe;
  logic [9:0] i_mem_out = '0, i_mem_oe = '0, o_mem_in;
  logic i_emmc_clk = 1'b0, i_emmc_cmd_out = 1'b0, i_emmc_cmd_oe = 1'b0, i_mdio_clk = 1'b0;
  logic i_mdio_d_out = 1'b0, i_mdio_d_oe = 1'b0, i_rgmii_txc = 1'b0, i_rgmii_txctl = 1'b0;
  logic [7:0] i_emmc_dat_out = '0, i_emmc_dat_oe = '0, o_emmc_dat_in;
  logic [4:0] i_vout_ctl = '0, o_vin_a_ctl;
  logic [23:0] i_vout_d = '0, o_vin_a_d;
  logic [19:5] i_trace_out = '0, i_trace_oe = '0, o_trace_in;
  logic [3:0] i_rgmii_txd = '0, o_rgmii_rxd;
  logic o_emmc_cmd_in, o_mdio_d_in, o_rgmii_rxc, o_rgmii_rxctl;
  logic [2:0] o_vin_b_ctl;
  logic [17:0] o_exp2, o_exp3, exp2m, exp3m;
  logic ctrl0, fp, boot, dip;
  logic [2:0] selm [0:38];
  logic [2:0] tab [0:5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
  logic [31:0] seed = 32'h0000005a;
  int errors = 0, comparisons = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  pfbms_if pfbms_if_inst ();
  pfbms_board_ctl pfbms_board_ctl_inst (.bus(pfbms_if_inst.ctl), .*);
  pfbms_pad_mux pfbms_pad_mux_inst (.bus(pfbms_if_inst.dev), .*);
  pfbms_chk pfbms_chk_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .cfg_addr(pfbms_if_inst.cfg_addr),
    .cfg_wdata(pfbms_if_inst.cfg_wdata), .cfg_wr(pfbms_if_inst.cfg_wr), .cfg_rdata(pfbms_if_inst.cfg_rdata),
    .first_port_sel(pfbms_if_inst.first_port_sel));

  // ----------------------------------------
  // Helpers and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
  endtask

  // Data is taken at the end of the cycle it stands in
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    d = o_rdata;
  endtask

  task automatic rdc(input string n, input logic [8:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(n, d, e);
  endtask

  task automatic reset_dut();
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    i_nrst <= 1'b0;
    {i_boot_emmc, i_dip_pos3} <= 2'h0;
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    {exp2m, exp3m, ctrl0, fp, boot, dip} = {36'h0, 1'b0, 1'b1, 2'h0};
    for (int p = 0; p < 39; p++) selm[p] = pfbms_pkg::FN_1;
  endtask

  function automatic logic [31:0] stat_exp();
    return {25'h0, {exp3m[12], exp3m[11]} == pfbms_pkg::MUXF_GIG, {exp2m[17], exp2m[14]} == pfbms_pkg::MUXE_TRACE,
      {exp3m[6], exp3m[2]} == pfbms_pkg::MUXD_ONBOARD, boot && !ctrl0, fp, dip, boot};
  endfunction

  // Expected {oe, out} of one pad for the model's select
  function automatic logic [1:0] po(input int p);
    int k;
    logic [2:0] s;
    k = p - 15;
    s = selm[p];
    if (p < 10) begin
      if (s == pfbms_pkg::FN_1) return {i_mem_oe[p], i_mem_out[p]};
      if (s != pfbms_pkg::FN_2) return 2'h0;
      if (p == 4) return {1'b1, i_emmc_clk};
      if (p == 9) return {i_emmc_cmd_oe, i_emmc_cmd_out};
      k = (p < 4) ? p + 4 : p - 5;
      return {i_emmc_dat_oe[k], i_emmc_dat_out[k]};
    end
    if (p < 15) begin
      k = p - 10;
      if (s == pfbms_pkg::FN_6) return {i_trace_oe[k + 5], i_trace_out[k + 5]};
      if (s != pfbms_pkg::FN_5) return 2'h0;
      return {1'b1, i_vout_ctl[(k == 0) ? 2 : (k == 2) ? 0 : k]};
    end
    if (s == pfbms_pkg::FN_5) return {1'b1, i_vout_d[23 - k]};
    if (s == pfbms_pkg::FN_6 && k < 10) return {i_trace_oe[k + 10], i_trace_out[k + 10]};
    if (s != pfbms_pkg::FN_4 || k < 10 || k > 17) return 2'h0;
    if (k == 10) return fp ? 2'h0 : {1'b1, i_mdio_clk};
    if (k == 11) return fp ? 2'h0 : {i_mdio_d_oe, i_mdio_d_out};
    if (k == 12) return {1'b1, i_rgmii_txc};
    if (k == 13) return {1'b1, i_rgmii_txctl};
    return {1'b1, i_rgmii_txd[17 - k]};
  endfunction

  function automatic logic hit(input int p, input logic [2:0] f);
    return (selm[p] == f) ? i_pad_in[p] : 1'b0;
  endfunction

  task automatic check_pads();
    logic [38:0] eo, ee;
    logic [9:0] mem;
    logic [7:0] dat;
    logic [4:0] ctl;
    logic [23:0] vd;
    logic [19:5] tr;
    logic [5:0] eth;
    for (int p = 0; p < 39; p++) {ee[p], eo[p]} = po(p);
    for (int n = 0; n < 10; n++) mem[n] = hit(n, pfbms_pkg::FN_1);
    for (int n = 0; n < 4; n++) {dat[n + 4], dat[n]} = {hit(n, pfbms_pkg::FN_2), hit(n + 5, pfbms_pkg::FN_2)};
    for (int n = 0; n < 5; n++) {ctl[n], tr[n + 5]} = {hit(n + 10, pfbms_pkg::FN_1), hit(n + 10, pfbms_pkg::FN_6)};
    for (int n = 0; n < 24; n++) vd[n] = hit(n + 15, pfbms_pkg::FN_1);
    for (int n = 0; n < 10; n++) tr[n + 10] = hit(n + 15, pfbms_pkg::FN_6);
    for (int n = 0; n < 6; n++) eth[5 - n] = hit(n + 33, pfbms_pkg::FN_4);
    check("pad_out", o_pad_out, eo);
    check("pad_oe", o_pad_oe, ee);
    check("mem_emmc_in", {o_mem_in, o_emmc_cmd_in, o_emmc_dat_in}, {mem, hit(9, pfbms_pkg::FN_2), dat});
    check("video_in", {o_vin_a_ctl, o_vin_a_d, o_trace_in}, {ctl, vd, tr});
    check("port_b_in", o_vin_b_ctl, {hit(14, pfbms_pkg::FN_4), hit(13, pfbms_pkg::FN_4), hit(11, pfbms_pkg::FN_4)});
    check("eth_in", {o_mdio_d_in, o_rgmii_rxc, o_rgmii_rxctl, o_rgmii_rxd},
      {fp ? 1'b0 : hit(26, pfbms_pkg::FN_4), eth});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    reset_dut();
    check("exp_images", {o_exp2, o_exp3}, 36'h0);
    rdc("stat", pfbms_pkg::REG_STAT, stat_exp());
    rdc("unmapped", 9'h010, 32'h0);
    rdc("pad_oob", 9'h19c, 32'h0);
    rdc("mdio_ok", 9'h1c0, 32'h0);
    for (int r = 0; r < 5; r++) begin
      {boot, dip, ctrl0, exp2m, exp3m} = {r != 0, r[0], r[2], 18'(rnd()), 18'(rnd())};
      i_boot_emmc <= boot;
      i_dip_pos3 <= dip;
      wr(pfbms_pkg::REG_EXP2, {14'h0, exp2m});
      wr(pfbms_pkg::REG_EXP3, {14'h0, exp3m});
      wr(pfbms_pkg::REG_CTRL, {31'h0, ctrl0});
      wr(pfbms_pkg::REG_STAT, rnd());
      fp = (exp2m[4] == pfbms_pkg::MUXJ_GIG);
      i_wr <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      check("exp2", o_exp2, exp2m);
      check("exp3", o_exp3, {exp3m[17:16], boot && !ctrl0 ? (dip ? 2'h1 : 2'h2) : exp3m[15:14], exp3m[13:0]});
      check("first_port", pfbms_if_inst.first_port_sel, fp);
      rd(pfbms_pkg::REG_EXP3, v);
      check("exp3_reg", v[17:0], exp3m);
      rdc("stat", pfbms_pkg::REG_STAT, stat_exp());
    end
    for (int r = 0; r < 10; r++) begin
      exp2m[4] = r[1];
      fp = (exp2m[4] == pfbms_pkg::MUXJ_GIG);
      wr(pfbms_pkg::REG_EXP2, {14'h0, exp2m});
      for (int p = 0; p < 39; p++) begin
        selm[p] = tab[(r < 6) ? r : (r == 8) ? 2 : rnd() % 6];
        wr({1'b1, 6'(p), 2'h0}, {29'h0, selm[p]});
        rdc("pad_sel", {1'b1, 6'(p), 2'h0}, {29'h0, selm[p]});
      end
      rdc("mdio_ok", 9'h1c0, {31'h0, !fp});
      {i_mem_out, i_mem_oe, i_emmc_clk, i_emmc_cmd_out, i_emmc_cmd_oe} <= 23'(rnd());
      {i_emmc_dat_out, i_emmc_dat_oe, i_vout_ctl, i_mdio_clk, i_mdio_d_out} <= 23'(rnd());
      {i_mdio_d_oe, i_rgmii_txc, i_rgmii_txctl, i_rgmii_txd, i_vout_d} <= 31'(rnd());
      {i_trace_out, i_trace_oe} <= 30'(rnd());
      i_pad_in <= 39'({rnd(), rnd()});
      repeat (6) @(posedge i_clk_sys);
      check_pads();
    end
    reset_dut();
    @(posedge i_clk_sys);
    check("exp_after_reset", {o_exp2, pfbms_if_inst.first_port_sel}, 19'h1);
    rdc("pad_after_reset", 9'h150, 32'h1);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    final_report();
  end
endmodule
